/* File: hw/msq_defines.vh */
// shared constants for the modem symbol and sync qualifier block
`ifndef MSQ_DEFINES_VH
`define MSQ_DEFINES_VH
`define MSQ_FMT_2FSK 3'h0
`define MSQ_FMT_GFSK 3'h1
`define MSQ_FMT_OOK 3'h3
`define MSQ_FMT_4FSK 3'h4
`define MSQ_FMT_ASK 3'h5
`define MSQ_FMT_MSK 3'h7
`define MSQ_SM_NONE 2'h0
`define MSQ_SM_15OF16 2'h1
`define MSQ_SM_16OF16 2'h2
`define MSQ_SM_30OF32 2'h3
`define MSQ_SM_CS_BIT 2
`define MSQ_ERR16_MAX 5'h01
`define MSQ_ERR32_MAX 6'h02
`define MSQ_DEV_BASE 4'h8
`define MSQ_LVL_FULL 5'h03
`define MSQ_LVL_THIRD 5'h01
`define MSQ_GAUSS_SHIFT 2
`define MSQ_PQ_INC 8'h01
`define MSQ_PQ_DEC 8'h08
`define MSQ_PQ_MAX 8'hff
`define MSQ_PQ_SCALE 2
`define MSQ_PIN_PQ 6'h08
`define MSQ_PIN_CS 6'h0e
`define MSQ_ST_CS 6
`define MSQ_ST_PQ 5
`define MSQ_ST_SYNC 3
`define MSQ_ST_PIN 0
`define MSQ_PA_FULL 8'hff
`define MSQ_BYTE_LAST 3'h7
`endif

/* File: hw/msq_sync_match.v */
// sync word bit-error counter over the last 16 and 32 received bits
`timescale 1ns/1ps
`include "msq_defines.vh"
module msq_sync_match #(
	parameter SYNC_W = 16
) (
	input wire [2*SYNC_W-1:0] rx_shift,
	input wire [SYNC_W-1:0] sync_word,
	output reg [5:0] err_short,
	output reg [5:0] err_long
);
	wire [2*SYNC_W-1:0] diff;
	integer k;
	genvar g;
	// the long pattern is the sync word sent twice
	generate
		for (g = 0; g < 2*SYNC_W; g = g + 1) begin : g_diff
			assign diff[g] = rx_shift[g] ^ sync_word[g % SYNC_W];
		end
	endgenerate
	always @* begin
		err_short = 6'h00;
		err_long = 6'h00;
		for (k = 0; k < 2*SYNC_W; k = k + 1) begin
			err_long = err_long + {5'h00, diff[k]};
			if (k < SYNC_W) begin
				err_short = err_short + {5'h00, diff[k]};
			end
		end
	end
endmodule // msq_sync_match

/* File: hw/msq_modem.v */
// modem symbol mapper, line coder, sync qualifier and rssi status
`timescale 1ns/1ps
`include "msq_defines.vh"
module msq_modem #(
	parameter SYNC_W = 16,
	parameter RSSI_W = 8
) (
	input wire sys_clk,
	input wire rst_b,
	input wire clk_en,
	input wire [2:0] mod_format,
	input wire manch_en,
	input wire [2:0] dev_mantissa,
	input wire [2:0] dev_exponent,
	input wire [2:0] sync_mode,
	input wire [SYNC_W-1:0] sync_word,
	input wire [2:0] preamble_quality_threshold,
	input wire attach_trailer_bytes,
	input wire [1:0] rssi_avg_len,
	input wire [RSSI_W-1:0] cs_abs_thr,
	input wire [3:0] cs_hyst,
	input wire [5:0] pin_function_select,
	input wire [7:0] ask_low_level,
	input wire [7:0] ask_ramp_step,
	input wire sym_tick,
	input wire tx_en,
	input wire tx_bit_valid,
	input wire [1:0] tx_bit_data,
	input wire tx_bit_hdr,
	input wire rx_en,
	input wire rx_chip_stb,
	input wire rx_chip,
	input wire rssi_sample_stb,
	input wire [RSSI_W-1:0] rssi_sample,
	input wire pkt_end,
	output wire tx_ready,
	output wire [15:0] tx_freq_off,
	output wire [2:0] msk_trans_frac,
	output wire pa_on,
	output wire [7:0] pa_level,
	output wire [11:0] rx_dev_expect,
	output wire [7:0] rx_byte,
	output wire rx_byte_stb,
	output wire [RSSI_W-1:0] rssi_status,
	output wire carrier_sense,
	output wire preamble_quality_hit,
	output wire sync_found,
	output wire pin_out,
	output wire [7:0] packet_status_reg
);
	wire is_msk = (mod_format == `MSQ_FMT_MSK);
	wire is_gfsk = (mod_format == `MSQ_FMT_GFSK);
	wire is_4fsk = (mod_format == `MSQ_FMT_4FSK);
	wire is_ook = (mod_format == `MSQ_FMT_OOK);
	wire is_ask = (mod_format == `MSQ_FMT_ASK);
	wire is_am = is_ook | is_ask;
	// deviation in units of fxosc/2^17
	wire [11:0] dev_word = {8'h00, `MSQ_DEV_BASE + {1'b0, dev_mantissa}} << dev_exponent;

	// transmit path
	reg tx_ready_r;
	reg hold_full_r;
	reg [1:0] hold_data_r;
	reg hold_hdr_r;
	reg chip_phase_r;
	reg [4:0] tap0_r;
	reg [4:0] tap1_r;
	reg [4:0] tap2_r;
	reg chip_on_r;
	reg sym_live_r;
	reg [15:0] tx_freq_off_r;
	reg [2:0] msk_trans_frac_r;
	reg pa_on_r;
	reg [7:0] pa_level_r;
	reg [11:0] rx_dev_expect_r;
	reg [4:0] lvl_nxt;
	reg chip_nxt;
	reg [4:0] base_lvl;

	always @* begin
		base_lvl = 5'h00;
		// header always goes out on two levels, even in 4-level mode
		if (is_4fsk && !hold_hdr_r) begin
			case (hold_data_r)
				2'b01: base_lvl = -`MSQ_LVL_FULL;
				2'b00: base_lvl = -`MSQ_LVL_THIRD;
				2'b10: base_lvl = `MSQ_LVL_THIRD;
				2'b11: base_lvl = `MSQ_LVL_FULL;
				default: base_lvl = 5'h00;
			endcase
		end else begin
			base_lvl = hold_data_r[0] ? `MSQ_LVL_FULL : -`MSQ_LVL_FULL;
		end
		chip_nxt = hold_data_r[0];
		lvl_nxt = base_lvl;
		// second manchester chip is the complement of the first
		if (manch_en && chip_phase_r) begin
			chip_nxt = ~hold_data_r[0];
			lvl_nxt = -base_lvl;
		end
		if (is_msk) begin
			lvl_nxt = -lvl_nxt;
		end
	end

	wire consume = sym_tick && tx_en && hold_full_r && (!manch_en || chip_phase_r);
	wire emit = sym_tick && tx_en && hold_full_r;

	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_ready_r <= 1'b0;
			hold_full_r <= 1'b0;
			hold_data_r <= 2'b00;
			hold_hdr_r <= 1'b0;
			chip_phase_r <= 1'b0;
			tap0_r <= 5'h00;
			tap1_r <= 5'h00;
			tap2_r <= 5'h00;
			chip_on_r <= 1'b0;
			sym_live_r <= 1'b0;
		end else if (clk_en) begin
			tx_ready_r <= tx_en && !(hold_full_r && !consume) && !(tx_bit_valid && tx_ready_r);
			if (tx_bit_valid && tx_ready_r) begin
				hold_full_r <= 1'b1;
				hold_data_r <= tx_bit_data;
				hold_hdr_r <= tx_bit_hdr;
			end else if (consume || !tx_en) begin
				hold_full_r <= 1'b0;
			end
			if (!tx_en) begin
				chip_phase_r <= 1'b0;
			end else if (emit && manch_en) begin
				chip_phase_r <= ~chip_phase_r;
			end
			// an empty slot sends a zero level with the carrier off
			if (sym_tick && tx_en) begin
				tap0_r <= emit ? lvl_nxt : 5'h00;
				tap1_r <= tap0_r;
				tap2_r <= tap1_r;
				chip_on_r <= emit && chip_nxt;
				sym_live_r <= emit;
			end else if (!tx_en) begin
				tap0_r <= 5'h00;
				tap1_r <= 5'h00;
				tap2_r <= 5'h00;
				chip_on_r <= 1'b0;
				sym_live_r <= 1'b0;
			end
		end
	end

	// gaussian taps 1-2-1 over three symbols; costs one symbol of latency
	wire [4:0] gauss_sum = tap2_r + {tap1_r[3:0], 1'b0} + tap0_r;
	wire [4:0] lvl_sum = is_gfsk ? gauss_sum : {tap0_r[2:0], 2'b00};
	wire signed [17:0] freq_prod = $signed({1'b0, dev_word}) * $signed(lvl_sum);
	wire [17:0] freq_scaled = freq_prod >>> `MSQ_GAUSS_SHIFT;
	wire [7:0] ask_target = chip_on_r ? `MSQ_PA_FULL : ask_low_level;

	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_freq_off_r <= 16'h0000;
			msk_trans_frac_r <= 3'h0;
			pa_on_r <= 1'b0;
			pa_level_r <= 8'h00;
			rx_dev_expect_r <= 12'h000;
		end else if (clk_en) begin
			tx_freq_off_r <= is_am ? 16'h0000 : freq_scaled[15:0];
			msk_trans_frac_r <= is_msk ? dev_mantissa : 3'h0;
			rx_dev_expect_r <= (is_msk || is_am) ? 12'h000 : dev_word;
			if (is_ook) begin
				pa_on_r <= chip_on_r;
				pa_level_r <= chip_on_r ? `MSQ_PA_FULL : 8'h00;
			end else if (is_ask) begin
				pa_on_r <= sym_live_r;
				// zero step means hard keying, otherwise a linear ramp
				if (ask_ramp_step == 8'h00) begin
					pa_level_r <= ask_target;
				end else if (pa_level_r < ask_target) begin
					pa_level_r <= (ask_target - pa_level_r > ask_ramp_step) ?
						pa_level_r + ask_ramp_step : ask_target;
				end else begin
					pa_level_r <= (pa_level_r - ask_target > ask_ramp_step) ?
						pa_level_r - ask_ramp_step : ask_target;
				end
			end else begin
				pa_on_r <= sym_live_r;
				pa_level_r <= `MSQ_PA_FULL;
			end
		end
	end

	// receive path
	reg rx_en_d_r;
	reg rx_phase_r;
	reg rx_first_r;
	reg [2*SYNC_W-1:0] rx_shift_r;
	reg prev_bit_r;
	reg [7:0] pq_cnt_r;
	reg pq_hit_r;
	reg sync_found_r;
	reg cs_r;
	reg [2:0] bit_cnt_r;
	reg [7:0] byte_sh_r;
	reg [7:0] rx_byte_r;
	reg rx_byte_stb_r;
	reg pin_out_r;
	reg [7:0] pkt_status_r;
	reg [RSSI_W-1:0] rssi_last_r;
	wire [5:0] err_short;
	wire [5:0] err_long;

	wire rx_enter = rx_en && !rx_en_d_r;
	wire chip_in = is_msk ? ~rx_chip : rx_chip;
	wire bit_stb = rx_en && rx_chip_stb && (!manch_en || rx_phase_r);
	wire bit_val = manch_en ? rx_first_r : chip_in;
	wire [2*SYNC_W-1:0] shift_nxt = {rx_shift_r[2*SYNC_W-2:0], bit_val};
	wire [7:0] pq_limit = {3'h0, preamble_quality_threshold, 2'b00};
	wire pq_gate = (preamble_quality_threshold == 3'h0) || (pq_cnt_r >= pq_limit);
	wire sync_en = (sync_mode[1:0] != `MSQ_SM_NONE);
	wire cs_ok = !sync_mode[`MSQ_SM_CS_BIT] || cs_r;

	msq_sync_match #(
		.SYNC_W(SYNC_W)
	) u_match (
		.rx_shift(shift_nxt),
		.sync_word(sync_word),
		.err_short(err_short),
		.err_long(err_long)
	);

	reg word_ok;
	always @* begin
		case (sync_mode[1:0])
			`MSQ_SM_15OF16: word_ok = (err_short[4:0] <= `MSQ_ERR16_MAX);
			`MSQ_SM_16OF16: word_ok = (err_short == 6'h00);
			`MSQ_SM_30OF32: word_ok = (err_long <= `MSQ_ERR32_MAX);
			default: word_ok = 1'b0;
		endcase
	end
	wire sync_hit = bit_stb && sync_en && !sync_found_r && word_ok && pq_gate && cs_ok;
	// data flows only once sync is held, or without sync when carrier sense is met or not required
	wire rx_pass = sync_en ? sync_found_r : cs_ok;

	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_en_d_r <= 1'b0;
			rx_phase_r <= 1'b0;
			rx_first_r <= 1'b0;
			rx_shift_r <= {2*SYNC_W{1'b0}};
			prev_bit_r <= 1'b0;
			pq_cnt_r <= 8'h00;
			pq_hit_r <= 1'b0;
			sync_found_r <= 1'b0;
			bit_cnt_r <= 3'h0;
			byte_sh_r <= 8'h00;
			rx_byte_r <= 8'h00;
			rx_byte_stb_r <= 1'b0;
		end else if (clk_en) begin
			rx_en_d_r <= rx_en;
			rx_byte_stb_r <= 1'b0;
			if (!rx_en || rx_enter) begin
				rx_phase_r <= 1'b0;
				pq_cnt_r <= 8'h00;
				sync_found_r <= 1'b0;
				bit_cnt_r <= 3'h0;
			end else begin
				if (rx_chip_stb && manch_en) begin
					rx_phase_r <= ~rx_phase_r;
					if (!rx_phase_r) begin
						rx_first_r <= chip_in;
					end
				end
				if (bit_stb) begin
					rx_shift_r <= shift_nxt;
					prev_bit_r <= bit_val;
					// counter saturates at both ends
					if (bit_val != prev_bit_r) begin
						pq_cnt_r <= (pq_cnt_r == `MSQ_PQ_MAX) ? pq_cnt_r : pq_cnt_r + `MSQ_PQ_INC;
					end else begin
						pq_cnt_r <= (pq_cnt_r < `MSQ_PQ_DEC) ? 8'h00 : pq_cnt_r - `MSQ_PQ_DEC;
					end
				end
				if (sync_hit) begin
					sync_found_r <= 1'b1;
					bit_cnt_r <= 3'h0;
				end else if (bit_stb && rx_pass) begin
					byte_sh_r <= {byte_sh_r[6:0], bit_val};
					bit_cnt_r <= bit_cnt_r + 3'h1;
					if (bit_cnt_r == `MSQ_BYTE_LAST) begin
						rx_byte_r <= {byte_sh_r[6:0], bit_val};
						rx_byte_stb_r <= 1'b1;
					end
				end
				// trailer byte takes precedence over a coincident data byte
				if (pkt_end && attach_trailer_bytes) begin
					rx_byte_r <= rssi_last_r;
					rx_byte_stb_r <= 1'b1;
				end
			end
			pq_hit_r <= rx_en && (pq_cnt_r > pq_limit);
		end
	end

	// rssi averaging, freeze and carrier sense
	reg [RSSI_W+2:0] rssi_acc_r;
	reg [2:0] rssi_cnt_r;
	reg [RSSI_W-1:0] rssi_status_r;
	wire [RSSI_W+2:0] acc_sum = rssi_acc_r + {{3{rssi_sample[RSSI_W-1]}}, rssi_sample};
	wire [RSSI_W+2:0] acc_avg = $signed(acc_sum) >>> rssi_avg_len;
	wire [2:0] cnt_last = (3'h1 << rssi_avg_len) - 3'h1;
	wire avg_done = rx_en && rssi_sample_stb && (rssi_cnt_r == cnt_last);
	wire signed [RSSI_W:0] avg_s = $signed(acc_avg[RSSI_W:0]);
	wire signed [RSSI_W:0] thr_s = $signed({cs_abs_thr[RSSI_W-1], cs_abs_thr});
	wire signed [RSSI_W:0] thr_lo = thr_s - $signed({{(RSSI_W-3){1'b0}}, cs_hyst});
	wire rssi_frozen = sync_en && sync_found_r;

	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rssi_acc_r <= {(RSSI_W+3){1'b0}};
			rssi_cnt_r <= 3'h0;
			rssi_status_r <= {RSSI_W{1'b0}};
			rssi_last_r <= {RSSI_W{1'b0}};
			cs_r <= 1'b0;
			pin_out_r <= 1'b0;
			pkt_status_r <= 8'h00;
		end else if (clk_en) begin
			if (!rx_en || rx_enter) begin
				rssi_acc_r <= {(RSSI_W+3){1'b0}};
				rssi_cnt_r <= 3'h0;
			end else if (rssi_sample_stb) begin
				rssi_acc_r <= avg_done ? {(RSSI_W+3){1'b0}} : acc_sum;
				rssi_cnt_r <= avg_done ? 3'h0 : rssi_cnt_r + 3'h1;
			end
			if (avg_done) begin
				rssi_last_r <= acc_avg[RSSI_W-1:0];
				// signed half-db value kept as is for software to read
				if (!rssi_frozen) begin
					rssi_status_r <= acc_avg[RSSI_W-1:0];
				end
				if (avg_s > thr_s) begin
					cs_r <= 1'b1;
				end else if (avg_s < thr_lo) begin
					cs_r <= 1'b0;
				end
			end
			if (!rx_en) begin
				cs_r <= 1'b0;
			end
			case (pin_function_select)
				`MSQ_PIN_PQ: pin_out_r <= pq_hit_r;
				`MSQ_PIN_CS: pin_out_r <= cs_r;
				default: pin_out_r <= 1'b0;
			endcase
			pkt_status_r <= 8'h00;
			pkt_status_r[`MSQ_ST_CS] <= cs_r;
			pkt_status_r[`MSQ_ST_PQ] <= pq_hit_r;
			pkt_status_r[`MSQ_ST_SYNC] <= sync_found_r;
			pkt_status_r[`MSQ_ST_PIN] <= pin_out_r;
		end
	end

	assign tx_ready = tx_ready_r;
	assign tx_freq_off = tx_freq_off_r;
	assign msk_trans_frac = msk_trans_frac_r;
	assign pa_on = pa_on_r;
	assign pa_level = pa_level_r;
	assign rx_dev_expect = rx_dev_expect_r;
	assign rx_byte = rx_byte_r;
	assign rx_byte_stb = rx_byte_stb_r;
	assign rssi_status = rssi_status_r;
	assign carrier_sense = cs_r;
	assign preamble_quality_hit = pq_hit_r;
	assign sync_found = sync_found_r;
	assign pin_out = pin_out_r;
	assign packet_status_reg = pkt_status_r;
endmodule // msq_modem

/* File: test/msq_air_model.sv */
// remote radio model: sends a framed chip stream and periodic rssi samples
`timescale 1ns/1ps
module msq_air_model (
	input wire sys_clk,
	input wire go,
	input wire [3:0] gap,
	input wire [39:0] frame,
	input wire [7:0] rssi_lvl,
	output logic busy,
	output logic rx_chip_stb,
	output logic rx_chip,
	output logic rssi_sample_stb,
	output logic [7:0] rssi_sample
);
	logic [5:0] idx_r;
	logic [3:0] cnt_r;
	logic [2:0] rcnt_r;
	initial {busy, rx_chip_stb, rx_chip, rssi_sample_stb, rssi_sample, idx_r, cnt_r, rcnt_r} = '0;
	always @(posedge sys_clk) begin
		rx_chip_stb <= 1'b0;
		rssi_sample_stb <= 1'b0;
		rssi_sample <= ~rssi_lvl;
		rcnt_r <= rcnt_r + 3'h1;
		if (rcnt_r == 3'h0) begin
			rssi_sample_stb <= 1'b1;
			rssi_sample <= rssi_lvl;
		end
		if (go && !busy) begin
			busy <= 1'b1;
			idx_r <= 6'h28;
			cnt_r <= gap;
		end else if (busy) begin
			cnt_r <= cnt_r - 4'h1;
			if (cnt_r == 4'h0) begin
				cnt_r <= gap;
				rx_chip_stb <= 1'b1;
				rx_chip <= frame[idx_r-6'h1];
				idx_r <= idx_r - 6'h1;
				busy <= (idx_r != 6'h1);
			end
		// released line toggles so no stale bit can be mistaken for data
		end else begin
			rx_chip <= ~rx_chip;
		end
	end
endmodule // msq_air_model

/* File: test/msq_modem_assertions.sv */
// concurrent checks on the modem block ports
`timescale 1ns/1ps
module msq_modem_chk #(
	parameter RSSI_W = 8
) (
	input wire sys_clk,
	input wire rst_b,
	input wire clk_en,
	input wire tx_en,
	input wire rx_en,
	input wire [2:0] mod_format,
	input wire [2:0] dev_mantissa,
	input wire [2:0] dev_exponent,
	input wire [2:0] sync_mode,
	input wire [5:0] pin_function_select,
	input wire tx_ready,
	input wire [15:0] tx_freq_off,
	input wire [2:0] msk_trans_frac,
	input wire pa_on,
	input wire [11:0] rx_dev_expect,
	input wire [RSSI_W-1:0] rssi_status,
	input wire carrier_sense,
	input wire preamble_quality_hit,
	input wire sync_found,
	input wire pin_out,
	input wire [7:0] packet_status_reg
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	property p_pq_pin;
		pin_function_select == 6'h08 && $past(pin_function_select) == 6'h08 && $past(clk_en)
			|-> pin_out == $past(preamble_quality_hit);
	endproperty
	a_pq_pin: assert property (p_pq_pin) else $error("pin not following quality hit");
	property p_pq_stat;
		$past(clk_en) |-> packet_status_reg[5] == $past(preamble_quality_hit);
	endproperty
	a_pq_stat: assert property (p_pq_stat) else $error("quality status bit wrong");
	property p_cs_stat;
		$past(clk_en) |-> packet_status_reg[6] == $past(carrier_sense);
	endproperty
	a_cs_stat: assert property (p_cs_stat) else $error("carrier status bit wrong");
	property p_sync_stat;
		$past(clk_en) |-> packet_status_reg[3] == $past(sync_found);
	endproperty
	a_sync_stat: assert property (p_sync_stat) else $error("sync status bit wrong");
	property p_msk_frac;
		$past(rst_b) && $past(clk_en) && $past(mod_format) == 3'h7
			|-> msk_trans_frac == $past(dev_mantissa);
	endproperty
	a_msk_frac: assert property (p_msk_frac) else $error("msk transition fraction wrong");
	property p_dev_fsk;
		$past(rst_b) && $past(clk_en) && $past(mod_format) inside {3'h0, 3'h1, 3'h4}
			|-> rx_dev_expect == (12'({1'b1, $past(dev_mantissa)}) << $past(dev_exponent));
	endproperty
	a_dev_fsk: assert property (p_dev_fsk) else $error("fsk deviation wrong");
	property p_dev_off;
		$past(rst_b) && $past(clk_en) && $past(mod_format) inside {3'h3, 3'h5, 3'h7}
			|-> rx_dev_expect == 12'h0;
	endproperty
	a_dev_off: assert property (p_dev_off) else $error("deviation used outside fsk");
	property p_tx_off;
		// outputs trail the symbol taps by one edge, so idle shows two edges after tx_en drops
		(clk_en && !tx_en) [*2] |=> tx_freq_off == 16'h0 && !pa_on && !tx_ready;
	endproperty
	a_tx_off: assert property (p_tx_off) else $error("transmitter active while idle");
	property p_rssi_frz;
		sync_mode[1:0] != 2'h0 && $past(sync_mode[1:0]) != 2'h0 && $past(sync_found)
			&& sync_found && $past(rx_en) && rx_en |-> $stable(rssi_status);
	endproperty
	a_rssi_frz: assert property (p_rssi_frz) else $error("rssi moved after sync");
	property p_cs_off;
		(clk_en && !rx_en) [*2] |-> !carrier_sense && !preamble_quality_hit;
	endproperty
	a_cs_off: assert property (p_cs_off) else $error("receive flags set outside rx");
endmodule // msq_modem_chk
bind msq_modem msq_modem_chk #(.RSSI_W(RSSI_W)) chk_u (.sys_clk, .rst_b, .clk_en, .tx_en, .rx_en,
	.mod_format, .dev_mantissa, .dev_exponent, .sync_mode, .pin_function_select, .tx_ready,
	.tx_freq_off, .msk_trans_frac, .pa_on, .rx_dev_expect, .rssi_status, .carrier_sense,
	.preamble_quality_hit, .sync_found, .pin_out, .packet_status_reg);

/* File: test/msq_modem_bench.sv */
// self-checking bench for the modem symbol and sync qualifier
`timescale 1ns/1ps
module msq_modem_bench;
	logic sys_clk = 0, rst_b = 0, clk_en = 1, manch_en = 0, attach_trailer_bytes = 1;
	logic tx_en = 0, tx_bit_valid = 0, tx_bit_hdr = 0, rx_en = 0, sym_tick = 0, pkt_end = 0;
	logic go = 0;
	logic [2:0] mod_format = 0, dev_mantissa = 0, dev_exponent = 0, sync_mode = 3'h2;
	logic [2:0] preamble_quality_threshold = 0;
	logic [1:0] rssi_avg_len = 0, tx_bit_data = 0;
	logic [15:0] sync_word = 16'h3c5a, air_sync = 16'h3c5a, dv, fu;
	logic [7:0] cs_abs_thr = 8'h7f, ask_low_level = 0, ask_ramp_step = 0, rssi_lvl = 8'hc8;
	logic [7:0] data;
	logic [3:0] cs_hyst = 0, gap = 4'h3;
	logic [5:0] pin_function_select = 6'h08;
	wire rx_chip_stb, rx_chip, rssi_sample_stb, tx_ready, pa_on, rx_byte_stb, carrier_sense;
	wire preamble_quality_hit, sync_found, pin_out, busy;
	wire [15:0] tx_freq_off;
	wire [2:0] msk_trans_frac;
	wire [7:0] pa_level, rx_byte, rssi_status, packet_status_reg, rssi_sample;
	wire [11:0] rx_dev_expect;
	int seed = 85732, fail_count = 0, num_checks = 0, k;
	logic [7:0] q [$];
	msq_modem dut_u (.sys_clk, .rst_b, .clk_en, .mod_format, .manch_en, .dev_mantissa,
		.dev_exponent, .sync_mode, .sync_word, .preamble_quality_threshold,
		.attach_trailer_bytes, .rssi_avg_len, .cs_abs_thr, .cs_hyst, .pin_function_select,
		.ask_low_level, .ask_ramp_step, .sym_tick, .tx_en, .tx_bit_valid, .tx_bit_data,
		.tx_bit_hdr, .rx_en, .rx_chip_stb, .rx_chip, .rssi_sample_stb, .rssi_sample, .pkt_end,
		.tx_ready, .tx_freq_off, .msk_trans_frac, .pa_on, .pa_level, .rx_dev_expect, .rx_byte,
		.rx_byte_stb, .rssi_status, .carrier_sense, .preamble_quality_hit, .sync_found,
		.pin_out, .packet_status_reg);
	msq_air_model air_u (.sys_clk, .go, .gap, .frame({16'haaaa, air_sync, data}), .rssi_lvl,
		.busy, .rx_chip_stb, .rx_chip, .rssi_sample_stb, .rssi_sample);
	initial begin
		forever #25 sys_clk = ~sys_clk;
	end
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#5;
	endtask
	task automatic tick;
		sym_tick = 1'b1;
		cyc(1);
		sym_tick = 1'b0;
		cyc(2);
	endtask
	task automatic tx_sym(input logic [1:0] d, input logic h);
		for (k = 0; k < 40 && tx_ready !== 1'b1; k++) cyc(1);
		tx_bit_valid = 1'b1;
		tx_bit_data = d;
		tx_bit_hdr = h;
		cyc(1);
		tx_bit_valid = 1'b0;
		tick;
	endtask
	// three equal symbols so every shaping tap holds the same level
	task automatic tx_case(input logic [2:0] f, input logic [1:0] d, input logic h,
		input logic [15:0] e);
		mod_format = f;
		repeat (3) tx_sym(d, h);
		chk("tx_freq_off", tx_freq_off, e);
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		if (rx_byte_stb === 1'b1) begin
			if (q.size() == 0) chk("extra_byte", 16'h1, 16'h0);
			else chk("rx_byte", rx_byte, q.pop_front());
		end
	end
	initial begin
		#2000000;
		fail_count++;
		end_of_test;
	end
	initial begin
		repeat (16) @(posedge sys_clk);
		#5 rst_b = 1'b1;
		cyc(2);
		dev_mantissa = 3'($random(seed));
		dev_exponent = 3'($random(seed));
		ask_low_level = 8'($random(seed));
		dv = 16'({1'b1, dev_mantissa}) << dev_exponent;
		fu = dv * 16'h3;
		tx_en = 1'b1;
		manch_en = 1'b0;
		tx_case(3'h0, 2'h1, 1'b0, fu);
		chk("rx_dev", rx_dev_expect, dv);
		tx_case(3'h0, 2'h0, 1'b0, -fu);
		tx_case(3'h1, 2'h1, 1'b0, fu);
		tx_case(3'h4, 2'h1, 1'b0, -fu);
		tx_case(3'h4, 2'h0, 1'b0, -dv);
		tx_case(3'h4, 2'h2, 1'b0, dv);
		tx_case(3'h4, 2'h3, 1'b0, fu);
		tx_case(3'h4, 2'h2, 1'b1, -fu);
		tx_case(3'h7, 2'h1, 1'b1, -fu);
		chk("msk_frac", msk_trans_frac, dev_mantissa);
		chk("msk_rx_dev", rx_dev_expect, 16'h0);
		tx_case(3'h3, 2'h1, 1'b0, 16'h0);
		chk("ook_pa", pa_on, 1'b1);
		tx_case(3'h3, 2'h0, 1'b0, 16'h0);
		chk("ook_pa", pa_on, 1'b0);
		tx_case(3'h5, 2'h0, 1'b0, 16'h0);
		chk("ask_level", pa_level, ask_low_level);
		tx_case(3'h5, 2'h1, 1'b0, 16'h0);
		chk("ask_level", pa_level, 8'hff);
		mod_format = 3'h0;
		manch_en = 1'b1;
		tx_sym(2'h1, 1'b0);
		chk("manch_first", tx_freq_off, fu);
		// a tick while the enable is low must not advance the chip phase
		clk_en = 1'b0;
		tick;
		chk("frozen_chip", tx_freq_off, fu);
		clk_en = 1'b1;
		tick;
		chk("manch_second", tx_freq_off, -fu);
		manch_en = 1'b0;
		tx_en = 1'b0;
		rssi_avg_len = 2'($random(seed));
		cs_hyst = 4'($random(seed));
		data = 8'($random(seed));
		rx_en = 1'b1;
		cyc(150);
		chk("rssi", rssi_status, 8'hc8);
		q.push_back(data);
		go = 1'b1;
		cyc(1);
		go = 1'b0;
		for (k = 0; k < 400 && busy; k++) cyc(1);
		cyc(4);
		chk("sync", sync_found, 1'b1);
		chk("status_sync", packet_status_reg[3], 1'b1);
		rssi_lvl = 8'h10;
		cyc(150);
		chk("rssi_frozen", rssi_status, 8'hc8);
		q.push_back(8'h10);
		pkt_end = 1'b1;
		cyc(1);
		pkt_end = 1'b0;
		cyc(4);
		rx_en = 1'b0;
		cyc(2);
		rx_en = 1'b1;
		preamble_quality_threshold = 3'h7;
		gap = 4'h0;
		go = 1'b1;
		cyc(1);
		go = 1'b0;
		for (k = 0; k < 400 && busy; k++) cyc(1);
		cyc(150);
		chk("gated_sync", sync_found, 1'b0);
		chk("rssi_live", rssi_status, 8'h10);
		// one corrupted sync bit must still pass the 15 of 16 qualifier
		sync_mode = 3'h1;
		preamble_quality_threshold = 3'h0;
		air_sync = sync_word ^ 16'h0100;
		data = 8'($random(seed));
		q.push_back(data);
		go = 1'b1;
		cyc(1);
		go = 1'b0;
		for (k = 0; k < 400 && busy; k++) cyc(1);
		cyc(4);
		chk("sync_15of16", sync_found, 1'b1);
		chk("queue_left", 16'(q.size()), 16'h0);
		end_of_test;
	end
endmodule // msq_modem_bench
